// ### include/dtc_pkg.sv
// shared constants, register map and types of the dual timer register block
package dtc_pkg;

    // bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W  = 8;
    localparam int IDX_W  = 6;
    localparam int WIDE_W = 16;

    // register indices; byte address is four times the index
    localparam logic [IDX_W-1:0] IDX_CTRL      = 6'h02;
    localparam logic [IDX_W-1:0] IDX_LOW_LOAD  = 6'h04;
    localparam logic [IDX_W-1:0] IDX_HIGH_LOAD = 6'h05;
    localparam logic [IDX_W-1:0] IDX_LOW_CAP   = 6'h0a;
    localparam logic [IDX_W-1:0] IDX_HIGH_CAP  = 6'h0b;
    localparam logic [IDX_W-1:0] IDX_MODE      = 6'h0c;
    localparam logic [IDX_W-1:0] IDX_STATUS    = 6'h10;
    localparam logic [IDX_W-1:0] IDX_MASK      = 6'h11;

    // reset values and counter limits
    localparam logic [REG_W-1:0]  REG_RST  = 8'h00;
    localparam logic [WIDE_W-1:0] WIDE_RST = 16'h0000;
    localparam logic [WIDE_W-1:0] WIDE_MAX = 16'hffff;
    localparam logic [REG_W-1:0]  BYTE_MAX = 8'hff;

    // field positions of the mode register
    localparam int MODE_RUN8  = 0;
    localparam int MODE_DEMOD = 1;

    // field positions of the interrupt status and mask registers
    localparam int ST_WIDE_TOUT = 0;
    localparam int ST_WIDE_CAP  = 1;
    localparam int ST_BYTE_CAP  = 2;
    localparam int ST_W         = 3;

    // prescaler encodings of the wide timer
    localparam logic [1:0] PRESC_DIV1 = 2'h0;
    localparam logic [1:0] PRESC_DIV2 = 2'h1;
    localparam logic [1:0] PRESC_DIV4 = 2'h2;
    localparam logic [1:0] PRESC_DIV8 = 2'h3;

    // wide timer control register, bit 7 down to bit 0
    typedef struct packed {
        logic       wide_timer_run;
        logic       single_pass;
        logic       time_out;
        logic [1:0] wide_timer_prescale_select;
        logic       capture_ie;
        logic       time_out_ie;
        logic       wide_timer_pin_route;
    } dtc_ctrl_t;

    // avalon request as seen by the slave
    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writedata;
    } dtc_avmm_req_t;

    // wide timer events and results
    typedef struct packed {
        logic              time_out;
        logic              capture;
        logic              stop;
        logic              wave;
        logic [WIDE_W-1:0] capture_value;
    } dtc_wide_stat_t;

    // mask of prescaler bits that must all be one for a count tick
    function automatic logic [2:0] dtc_presc_mask(input logic [1:0] sel);
        unique case (sel)
            PRESC_DIV1: dtc_presc_mask = 3'h0;
            PRESC_DIV2: dtc_presc_mask = 3'h1;
            PRESC_DIV4: dtc_presc_mask = 3'h3;
            PRESC_DIV8: dtc_presc_mask = 3'h7;
        endcase
    endfunction : dtc_presc_mask

endpackage : dtc_pkg

// ### rtl/dtc_wide_timer.sv
// sixteen-bit timer core: prescaler, down/up counter, time-out and edge capture
`timescale 1ns/1ps
module dtc_wide_timer #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic                clk_in,
    input  wire logic                nrst_in,
    // control
    input  wire dtc_pkg::dtc_ctrl_t  ctrl_in,
    input  wire logic                demod_in,
    input  wire logic [W-1:0]        reload_in,
    input  wire logic                edge_in,
    // results
    output dtc_pkg::dtc_wide_stat_t  stat_out
);
    import dtc_pkg::*;

    logic [2:0]   presc;
    logic [2:0]   next_presc;
    logic [W-1:0] count;
    logic [W-1:0] next_count;
    dtc_wide_stat_t stat;
    dtc_wide_stat_t next_stat;
    logic         tick;

    always_comb begin
        next_presc = presc;
        next_count = count;
        next_stat  = stat;
        next_stat.time_out = 1'b0;
        next_stat.capture  = 1'b0;
        next_stat.stop     = 1'b0;
        tick = ((presc & dtc_presc_mask(ctrl_in.wide_timer_prescale_select))
               == dtc_presc_mask(ctrl_in.wide_timer_prescale_select));
        // stopped counter holds its start value
        if (!ctrl_in.wide_timer_run) begin
            next_presc = 3'h0;
            next_count = demod_in ? WIDE_RST : reload_in;
        end else begin
            next_presc = presc + 3'h1;
            // edge recognised only when single bit is clear
            if (demod_in && edge_in && !ctrl_in.single_pass) begin
                next_stat.capture       = 1'b1;
                next_stat.capture_value = count;
                next_count              = WIDE_RST;
            end else if (tick) begin
                if (demod_in) begin
                    next_count = count + 16'h0001;
                    next_stat.time_out = (count == WIDE_MAX);
                end else if (count == WIDE_RST) begin
                    next_stat.time_out = 1'b1;
                    next_stat.wave     = ~stat.wave;
                    next_stat.stop     = ctrl_in.single_pass;
                    next_count         = reload_in;
                end else begin
                    next_count = count - 16'h0001;
                end
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            presc <= 3'h0;
            count <= WIDE_RST;
            stat  <= '0;
        end else begin
            presc <= next_presc;
            count <= next_count;
            stat  <= next_stat;
        end
    end

    assign stat_out = stat;

endmodule : dtc_wide_timer

// ### rtl/dtc_regs.sv
// dual timer register block: avalon slave, eight-bit timer, wide timer control
`timescale 1ns/1ps
module dtc_regs #(
    parameter logic [15:0] WIDE_RELOAD = 16'hffff
) (
    // clock and reset
    input  wire logic                        clk_in,
    input  wire logic                        nrst_in,
    // avalon-mm slave
    input  wire dtc_pkg::dtc_avmm_req_t      avmm_req_in,
    output logic [dtc_pkg::DATA_W-1:0]       avmm_readdata_out,
    output logic                             avmm_waitrequest_out,
    // measured input pin
    input  wire logic                        meas_pin_in,
    // eight-bit timer output
    output logic                             eight_bit_timer_output_out,
    // wide timer pin and its general-purpose fallback
    input  wire logic                        gpio_data_in,
    input  wire logic                        gpio_oe_in,
    output logic                             wide_pin_out,
    output logic                             wide_pin_oe_out,
    output logic [dtc_pkg::WIDE_W-1:0]       wide_capture_out,
    // interrupts
    output logic                             wide_tout_irq_out,
    output logic                             wide_cap_irq_out,
    output logic                             irq_out
);
    import dtc_pkg::*;

    // bus slave state
    logic                ack;
    logic                next_ack;
    logic [DATA_W-1:0]   rdata;
    logic [DATA_W-1:0]   next_rdata;
    logic                wr_en;
    logic [IDX_W-1:0]    idx;
    logic                aligned;
    logic [REG_W-1:0]    wbyte;

    // software registers
    dtc_ctrl_t           ctrl;
    dtc_ctrl_t           next_ctrl;
    logic [REG_W-1:0]    low_load;
    logic [REG_W-1:0]    next_low_load;
    logic [REG_W-1:0]    high_load;
    logic [REG_W-1:0]    next_high_load;
    logic [REG_W-1:0]    mode;
    logic [REG_W-1:0]    next_mode;
    logic [ST_W-1:0]     status;
    logic [ST_W-1:0]     next_status;
    logic [ST_W-1:0]     mask;
    logic [ST_W-1:0]     next_mask;

    // input synchroniser and filtered level
    logic [2:0]          meas_sync;
    logic [2:0]          next_meas_sync;
    logic                meas_lvl;
    logic                next_meas_lvl;
    logic                meas_edge;

    // eight-bit timer state
    logic [REG_W-1:0]    cnt8;
    logic [REG_W-1:0]    next_cnt8;
    logic                wave8;
    logic                next_wave8;
    logic [REG_W-1:0]    low_cap;
    logic [REG_W-1:0]    next_low_cap;
    logic [REG_W-1:0]    high_cap;
    logic [REG_W-1:0]    next_high_cap;
    logic                byte_cap;
    logic                next_byte_cap;

    // wide timer outputs and interrupt pulses
    dtc_wide_stat_t      wide;
    logic                tout_irq;
    logic                next_tout_irq;
    logic                cap_irq;
    logic                next_cap_irq;

    // ---------------- avalon slave ----------------
    // one wait cycle per access so read data come from a flop
    function automatic logic [DATA_W-1:0] widen(input logic [REG_W-1:0] v);
        widen = {{(DATA_W-REG_W){1'b0}}, v};
    endfunction : widen

    assign idx     = avmm_req_in.address[ADDR_W-1:2];
    assign aligned = (avmm_req_in.address[1:0] == 2'h0);
    assign wbyte   = avmm_req_in.writedata[REG_W-1:0];
    assign wr_en   = avmm_req_in.write && ack;
    assign avmm_waitrequest_out = (avmm_req_in.read || avmm_req_in.write) && !ack;

    always_comb begin
        next_ack   = (avmm_req_in.read || avmm_req_in.write) && !ack;
        next_rdata = rdata;
        if (avmm_req_in.read && !ack) begin
            next_rdata = '0;
            if (aligned) begin
                unique case (idx)
                    // run bit and the rest of control read back
                    IDX_CTRL:      next_rdata = widen(ctrl);
                    IDX_LOW_LOAD:  next_rdata = widen(low_load);
                    IDX_HIGH_LOAD: next_rdata = widen(high_load);
                    IDX_LOW_CAP:   next_rdata = widen(low_cap);
                    IDX_HIGH_CAP:  next_rdata = widen(high_cap);
                    IDX_MODE:      next_rdata = widen(mode);
                    IDX_STATUS:    next_rdata = widen({5'h00, status});
                    IDX_MASK:      next_rdata = widen({5'h00, mask});
                    default:       next_rdata = '0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ack   <= 1'b0;
            rdata <= '0;
        end else begin
            ack   <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign avmm_readdata_out = rdata;

    // ---------------- software registers ----------------
    always_comb begin
        next_ctrl      = ctrl;
        next_low_load  = low_load;
        next_high_load = high_load;
        next_mode      = mode;
        next_mask      = mask;
        next_status    = status;
        // hardware stop at the end of a single pass
        if (wide.stop) begin
            next_ctrl.wide_timer_run = 1'b0;
        end
        if (wr_en && aligned) begin
            unique case (idx)
                IDX_CTRL: begin
                    next_ctrl.wide_timer_run             = wbyte[7];
                    next_ctrl.single_pass                = wbyte[6];
                    next_ctrl.wide_timer_prescale_select = wbyte[4:3];
                    next_ctrl.capture_ie                 = wbyte[2];
                    next_ctrl.time_out_ie                = wbyte[1];
                    next_ctrl.wide_timer_pin_route       = wbyte[0];
                    if (wbyte[5]) begin
                        next_ctrl.time_out = 1'b0;
                    end
                end
                IDX_LOW_LOAD:  next_low_load  = wbyte;
                IDX_HIGH_LOAD: next_high_load = wbyte;
                IDX_MODE:      next_mode      = wbyte;
                IDX_STATUS:    next_status    = status & ~wbyte[ST_W-1:0];
                IDX_MASK:      next_mask      = wbyte[ST_W-1:0];
                default: ;
            endcase
        end
        // a time-out in the clearing cycle still sets the flag
        if (wide.time_out) begin
            next_ctrl.time_out = 1'b1;
        end
        // new events win over a clear in the same cycle
        next_status[ST_WIDE_TOUT] = next_status[ST_WIDE_TOUT] | wide.time_out;
        next_status[ST_WIDE_CAP]  = next_status[ST_WIDE_CAP] | wide.capture;
        next_status[ST_BYTE_CAP]  = next_status[ST_BYTE_CAP] | byte_cap;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            // all control bits reset to zero
            ctrl      <= dtc_ctrl_t'(REG_RST);
            low_load  <= REG_RST;
            high_load <= REG_RST;
            mode      <= REG_RST;
            status    <= '0;
            mask      <= '0;
        end else begin
            ctrl      <= next_ctrl;
            low_load  <= next_low_load;
            high_load <= next_high_load;
            mode      <= next_mode;
            status    <= next_status;
            mask      <= next_mask;
        end
    end

    // ---------------- measured input ----------------
    // a level change counts only once the last two stages agree
    always_comb begin
        next_meas_sync = {meas_sync[1:0], meas_pin_in};
        next_meas_lvl  = (meas_sync[1] == meas_sync[2]) ? meas_sync[2] : meas_lvl;
        meas_edge      = (next_meas_lvl != meas_lvl);
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            meas_sync <= 3'h0;
            meas_lvl  <= 1'b0;
        end else begin
            meas_sync <= next_meas_sync;
            meas_lvl  <= next_meas_lvl;
        end
    end

    // ---------------- eight-bit timer ----------------
    always_comb begin
        next_cnt8     = cnt8;
        next_wave8    = wave8;
        next_low_cap  = low_cap;
        next_high_cap = high_cap;
        next_byte_cap = 1'b0;
        if (!mode[MODE_RUN8]) begin
            next_cnt8  = REG_RST;
            next_wave8 = 1'b0;
        end else if (mode[MODE_DEMOD]) begin
            next_wave8 = 1'b0;
            if (meas_edge) begin
                next_byte_cap = 1'b1;
                next_cnt8     = REG_RST;
                // capture by the level that just ended
                if (meas_lvl) begin
                    next_high_cap = cnt8;
                end else begin
                    next_low_cap = cnt8;
                end
            end else if (cnt8 != BYTE_MAX) begin
                // saturates so an over-long level reads as full scale
                next_cnt8 = cnt8 + 8'h01;
            end
        end else begin
            // each level lasts its load value plus one cycle
            if (cnt8 == (wave8 ? high_load : low_load)) begin
                next_cnt8  = REG_RST;
                next_wave8 = ~wave8;
            end else begin
                next_cnt8 = cnt8 + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cnt8     <= REG_RST;
            wave8    <= 1'b0;
            low_cap  <= REG_RST;
            high_cap <= REG_RST;
            byte_cap <= 1'b0;
        end else begin
            cnt8     <= next_cnt8;
            wave8    <= next_wave8;
            low_cap  <= next_low_cap;
            high_cap <= next_high_cap;
            byte_cap <= next_byte_cap;
        end
    end

    assign eight_bit_timer_output_out = wave8;

    // ---------------- wide timer ----------------
    dtc_wide_timer #(
        .W         (WIDE_W)
    ) u_wide (
        .clk_in    (clk_in),
        .nrst_in   (nrst_in),
        .ctrl_in   (ctrl),
        .demod_in  (mode[MODE_DEMOD]),
        .reload_in (WIDE_RELOAD),
        .edge_in   (meas_edge),
        .stat_out  (wide)
    );

    assign wide_capture_out = wide.capture_value;

    // pin follows the timer only when routed
    assign wide_pin_out    = ctrl.wide_timer_pin_route ? wide.wave : gpio_data_in;
    assign wide_pin_oe_out = ctrl.wide_timer_pin_route ? 1'b1 : gpio_oe_in;

    // ---------------- interrupts ----------------
    always_comb begin
        // enabled events give a one-cycle request
        next_tout_irq = wide.time_out && ctrl.time_out_ie;
        next_cap_irq  = wide.capture && ctrl.capture_ie;
    end

    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            tout_irq <= 1'b0;
            cap_irq  <= 1'b0;
        end else begin
            tout_irq <= next_tout_irq;
            cap_irq  <= next_cap_irq;
        end
    end

    assign wide_tout_irq_out = tout_irq;
    assign wide_cap_irq_out  = cap_irq;
    assign irq_out           = |(status & mask);

endmodule : dtc_regs

// ### test/dtc_regs_properties.sv
// port-level assertions of the dual timer register block
`timescale 1ns/1ps
module dtc_regs_checker #(
    parameter logic [15:0] WIDE_RELOAD = 16'hffff
) (
    // clock and reset
    input wire logic                   clk_in,
    input wire logic                   nrst_in,
    // register bus
    input wire dtc_pkg::dtc_avmm_req_t avmm_req_in,
    input wire logic                   avmm_waitrequest_out,
    // pins and interrupts
    input wire logic                   eight_bit_timer_output_out,
    input wire logic                   gpio_data_in,
    input wire logic                   gpio_oe_in,
    input wire logic                   wide_pin_out,
    input wire logic                   wide_pin_oe_out,
    input wire logic                   wide_tout_irq_out,
    input wire logic                   wide_cap_irq_out,
    input wire logic                   irq_out
);
    import dtc_pkg::*;
    logic       acc;
    logic       req;
    logic [7:0] ctl_q;
    logic [7:0] mode_q;
    logic [7:0] mask_q;
    assign req = avmm_req_in.read || avmm_req_in.write;
    assign acc = avmm_req_in.write && !avmm_waitrequest_out;
    // shadow of the software-owned bits, taken from accepted writes
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            ctl_q  <= 8'h00;
            mode_q <= 8'h00;
            mask_q <= 8'h00;
        end else if (acc) begin
            if (avmm_req_in.address == 8'h08) ctl_q <= avmm_req_in.writedata[7:0];
            if (avmm_req_in.address == 8'h30) mode_q <= avmm_req_in.writedata[7:0];
            if (avmm_req_in.address == 8'h44) mask_q <= avmm_req_in.writedata[7:0];
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    a_bus_one_wait: assert property (req && avmm_waitrequest_out |=> !avmm_waitrequest_out)
        else $error("more than one wait cycle");
    a_bus_idle_ready: assert property (!req |-> !avmm_waitrequest_out)
        else $error("wait while bus idle");
    a_pin_gpio_path: assert property (!ctl_q[0] |->
        wide_pin_out == gpio_data_in && wide_pin_oe_out == gpio_oe_in)
        else $error("pin not general purpose");
    a_pin_routed_on: assert property (ctl_q[0] |-> wide_pin_oe_out)
        else $error("routed pin not driven");
    a_tout_irq_gate: assert property (wide_tout_irq_out |-> $past(ctl_q[1]))
        else $error("time-out request while disabled");
    a_cap_irq_gate: assert property (wide_cap_irq_out |-> $past(ctl_q[2]))
        else $error("capture request while disabled");
    a_tout_one_cycle: assert property (wide_tout_irq_out |=> !wide_tout_irq_out)
        else $error("time-out request too long");
    a_cap_one_cycle: assert property (wide_cap_irq_out |=> !wide_cap_irq_out)
        else $error("capture request too long");
    a_irq_level_set: assert property (wide_tout_irq_out && mask_q[0] |-> ##[0:1] irq_out)
        else $error("unmasked event gave no interrupt");
    a_eight_stopped_low: assert property (!mode_q[0] && !$past(mode_q[0])
        |-> !eight_bit_timer_output_out)
        else $error("stopped output not low");
    c_tout: cover property (wide_tout_irq_out && ctl_q[0]);
    c_cap: cover property (wide_cap_irq_out);
    c_irq: cover property (irq_out);
endmodule : dtc_regs_checker

bind dtc_regs dtc_regs_checker #(.WIDE_RELOAD(WIDE_RELOAD)) dtc_regs_checker_inst (
    .clk_in(clk_in), .nrst_in(nrst_in), .avmm_req_in(avmm_req_in),
    .avmm_waitrequest_out(avmm_waitrequest_out),
    .eight_bit_timer_output_out(eight_bit_timer_output_out),
    .gpio_data_in(gpio_data_in), .gpio_oe_in(gpio_oe_in), .wide_pin_out(wide_pin_out),
    .wide_pin_oe_out(wide_pin_oe_out), .wide_tout_irq_out(wide_tout_irq_out),
    .wide_cap_irq_out(wide_cap_irq_out), .irq_out(irq_out));

// ### test/dtc_pin_model.sv
// measured-signal source: low and high phases of set lengths, pulled high when idle
`timescale 1ns/1ps
module dtc_pin_model (
    // clock
    input  wire logic       clk_in,
    // waveform settings
    input  wire logic       en_in,
    input  wire logic [8:0] lo_len_in,
    input  wire logic [8:0] hi_len_in,
    // pin
    output logic            pin_out
);
    int cnt = 0;
    initial pin_out = 1'b1;
    always @(posedge clk_in) begin
        if (!en_in) begin
            pin_out <= 1'b1;
            cnt <= 0;
        end else if (cnt + 1 >= int'(pin_out ? hi_len_in : lo_len_in)) begin
            pin_out <= !pin_out;
            cnt <= 0;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule : dtc_pin_model

// ### test/tb.sv
// self-checking bench of the dual timer register block
`timescale 1ns/1ps
module tb;
    import dtc_pkg::*;
    localparam logic [15:0] RLD = 16'h0004;
    logic          clk_in = 1'b0;
    logic          nrst_in = 1'b0;
    dtc_avmm_req_t req = '0;
    logic [31:0]   rdata, q;
    logic [15:0]   wcap;
    logic          wait_req, eight_out, pin, pin_oe, t_irq, c_irq, irq, meas;
    logic          gpio_d = 1'b0, gpio_oe = 1'b0, pm_en = 1'b0;
    logic [8:0]    lo_len = 9'h010, hi_len = 9'h010;
    int            n_fail = 0;
    int            comparisons = 0;
    always #5 clk_in = ~clk_in;
    dtc_regs #(.WIDE_RELOAD(RLD)) dtc_regs_inst (.clk_in(clk_in), .nrst_in(nrst_in),
        .avmm_req_in(req), .avmm_readdata_out(rdata), .avmm_waitrequest_out(wait_req),
        .meas_pin_in(meas), .eight_bit_timer_output_out(eight_out), .gpio_data_in(gpio_d),
        .gpio_oe_in(gpio_oe), .wide_pin_out(pin), .wide_pin_oe_out(pin_oe),
        .wide_capture_out(wcap), .wide_tout_irq_out(t_irq), .wide_cap_irq_out(c_irq),
        .irq_out(irq));
    dtc_pin_model dtc_pin_model_inst (.clk_in(clk_in), .en_in(pm_en), .lo_len_in(lo_len),
        .hi_len_in(hi_len), .pin_out(meas));
    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // one access; request held until the edge at which waitrequest is low
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_in);
        req <= '{read: !wr, write: wr, address: a, writedata: d};
        // waitrequest is looked at mid-cycle, settled before the edge that takes it
        do begin
            @(negedge clk_in);
            n++;
        end while (wait_req !== 1'b0 && n < 64);
        @(posedge clk_in);
        q = rdata;
        if (n >= 64) begin
            n_fail++;
            report_and_stop();
        end
        req <= '0;
        @(posedge clk_in);
    endtask : bus
    function automatic logic pick(input int w);
        return w ? t_irq : eight_out;
    endfunction : pick
    // waits for a level, then counts the cycles it lasts
    task automatic span(input int w, input logic lvl, output int len);
        int n;
        n = 0;
        len = 0;
        // levels are sampled mid-cycle so no edge races the flop that drives them
        while (pick(w) !== lvl && n < 4000) begin
            @(negedge clk_in);
            n++;
        end
        while (pick(w) === lvl && len < 4000) begin
            @(negedge clk_in);
            len++;
        end
        if (n >= 4000 || len >= 4000) begin
            n_fail++;
            report_and_stop();
        end
    endtask : span
    initial begin
        int len, x;
        logic [7:0] ad [7];
        logic [7:0] lv [5];
        logic [7:0] hv [5];
        x = $urandom(32'hb63d9059);
        ad = '{8'h08, 8'h10, 8'h14, 8'h28, 8'h2c, 8'h3c, 8'h0a};
        for (int i = 0; i < 5; i++) begin
            lv[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom % 40);
            hv[i] = (i == 0) ? 8'h00 : (i == 1) ? 8'h01 : 8'($urandom % 40);
        end
        repeat (16) @(posedge clk_in);
        nrst_in <= 1'b1;
        @(posedge clk_in);
        foreach (ad[i]) begin
            bus(1'b0, ad[i], 0);
            check("reset or unmapped", q, 0);
        end
        for (int i = 0; i < 4; i++) begin
            x = $urandom;
            bus(1'b1, 8'h10, x);
            bus(1'b1, 8'h14, ~x);
            bus(1'b0, 8'h10, 0);
            check("low load", q, {24'h0, x[7:0]});
            bus(1'b0, 8'h14, 0);
            check("high load", q, {24'h0, ~x[7:0]});
        end
        for (int i = 0; i < 5; i++) begin
            bus(1'b1, 8'h30, 0);
            bus(1'b1, 8'h10, lv[i]);
            bus(1'b1, 8'h14, hv[i]);
            bus(1'b1, 8'h30, 1);
            span(0, 1'b1, x);
            span(0, 1'b0, len);
            check("low time", len, lv[i] + 1);
            span(0, 1'b1, len);
            check("high time", len, hv[i] + 1);
        end
        bus(1'b1, 8'h30, 0);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, 8'h08, 8'h83 | (s << 3));
            bus(1'b0, 8'h08, 0);
            check("control", q & 32'hdf, 8'h83 | (s << 3));
            check("pin enable", pin_oe, 1);
            span(1, 1'b1, x);
            span(1, 1'b0, len);
            check("time-out period", len + 1, (RLD + 1) << s);
        end
        bus(1'b1, 8'h08, 8'h00);
        bus(1'b0, 8'h08, 0);
        check("flag kept", q, 32'h20);
        gpio_d <= 1'b1;
        @(posedge clk_in);
        check("gpio pin", {pin, pin_oe}, 2'b10);
        bus(1'b0, 8'h40, 0);
        check("status", q, 1);
        bus(1'b1, 8'h44, 1);
        check("irq", irq, 1);
        bus(1'b1, 8'h44, 0);
        check("irq masked", irq, 0);
        bus(1'b1, 8'h44, 1);
        bus(1'b1, 8'h40, 1);
        check("irq cleared", irq, 0);
        bus(1'b1, 8'h08, 8'h20);
        bus(1'b0, 8'h08, 0);
        check("flag cleared", q, 0);
        bus(1'b1, 8'h08, 8'hc2);
        span(1, 1'b1, x);
        repeat (4) @(posedge clk_in);
        bus(1'b0, 8'h08, 0);
        check("single pass", q, 32'h62);
        lo_len <= 9'(6 + $urandom % 20);
        hi_len <= 9'(6 + $urandom % 20);
        pm_en <= 1'b1;
        bus(1'b1, 8'h30, 3);
        bus(1'b1, 8'h08, 8'h84);
        x = 0;
        repeat (200) begin
            @(negedge clk_in);
            x += c_irq;
        end
        check("edges seen", x > 0, 1);
        check("wide capture", wcap == lo_len - 1 || wcap == hi_len - 1, 1);
        bus(1'b0, 8'h28, 0);
        check("low capture", q >= lo_len - 1 && q <= lo_len + 1, 1);
        bus(1'b0, 8'h2c, 0);
        check("high capture", q >= hi_len - 1 && q <= hi_len + 1, 1);
        bus(1'b1, 8'h08, 8'hc4);
        repeat (8) @(posedge clk_in);
        x = 0;
        repeat (150) begin
            @(posedge clk_in);
            x += c_irq;
        end
        check("edges ignored", x, 0);
        pm_en <= 1'b0;
        repeat (20) @(posedge clk_in);
        bus(1'b0, 8'h28, 0);
        len = q;
        bus(1'b1, 8'h28, 32'hff);
        bus(1'b0, 8'h28, 0);
        check("capture write", q, len);
        report_and_stop();
    end
endmodule : tb
